// ### pkg/pvlfs_map.svh
// Register offsets, reset values, timing counts and band limits for
// the voltage loop filter selection block.
// Assumes inclusion by its bare name from the package and the design.
`ifndef PVLFS_MAP_SVH
`define PVLFS_MAP_SVH
`define PVLFS_ADDR_DITHER    16'hFE1D
`define PVLFS_ADDR_SYNC      16'hFE1E
`define PVLFS_ADDR_VGAIN     16'hFE20
`define PVLFS_ADDR_VZERO     16'hFE21
`define PVLFS_ADDR_FGAIN     16'hFE22
`define PVLFS_ADDR_FZERO     16'hFE23
`define PVLFS_ADDR_FCTL      16'hFE24
`define PVLFS_ADDR_STATUS    16'hFEF0
`define PVLFS_RST_DITHER     7'h00
`define PVLFS_RST_BYTE       8'h00
`define PVLFS_UNMAPPED_DATA  8'h00
`define PVLFS_CLK_PERIOD_NS  8
`define PVLFS_DITHER_LSB_NS  40000
`define PVLFS_BAND_BASE      16
`define PVLFS_LT_MARGIN      31
`endif

// ### pkg/pvlfs_pkg.sv
// Types shared by the voltage loop filter selection block.
// Assumes the map header is on the include path.
`include "pvlfs_map.svh"
package pvlfs_pkg;
  typedef struct packed {
    logic [7:0] gain;
    logic [7:0] zero;
  } pvlfs_coef_t;
  // Layout matches the fast loop control byte, bit 7 down to bit 0.
  typedef struct packed {
    logic       lt_en;
    logic [1:0] band;
    logic [2:0] delay;
    logic       ss_en;
    logic       dly_en;
  } pvlfs_ctl_t;
  typedef enum logic [1:0] {
    PVLFS_NORMAL,
    PVLFS_FAST,
    PVLFS_HOLD
  } pvlfs_state_t;
endpackage

// ### src/pvlfs_top.sv
// Voltage loop filter selection: coefficient store, normal/fast filter
// choice, dithering update timer and external sync frequency divider.
// Assumes all inputs are synchronous to sys_clk and strobes last one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "pvlfs_map.svh"
module pvlfs_top #(
  parameter int ERR_W       = 12,
  parameter int TICK_CYCLES = (`PVLFS_DITHER_LSB_NS + `PVLFS_CLK_PERIOD_NS
                               - 1) / `PVLFS_CLK_PERIOD_NS
) (
  input  wire logic               sys_clk,      // System clock, 125 MHz.
  input  wire logic               reset_n,      // Async reset, active low.
  input  wire logic [15:0]        reg_addr,     // Register address.
  input  wire logic [7:0]         reg_wdata,    // Write data.
  input  wire logic               reg_wr,       // Write strobe.
  input  wire logic               reg_rd,       // Read strobe.
  output logic      [7:0]         reg_rdata,    // Read data, registered.
  output logic                    reg_rvalid,   // Read data valid pulse.
  input  wire logic signed [ERR_W-1:0] vout_err, // Vout error, 1/1024 units.
  input  wire logic               half_cycle,   // Half line cycle strobe.
  input  wire logic               soft_start,   // Soft start in progress.
  input  wire logic               loop_update,  // Loop update boundary.
  input  wire logic               dither_en,    // Dithering active.
  input  wire logic               sync_edge,    // External sync edge strobe.
  output logic                    dither_update, // Frequency update pulse.
  output logic                    sw_tick,      // Switching period tick.
  output pvlfs_pkg::pvlfs_coef_t  coef_out,     // Coefficients in use.
  output logic                    fast_active   // Fast set in use.
);
  import pvlfs_pkg::*;
  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The band limit plus margin reaches 159, which needs eight bits of
  // magnitude plus a sign.
  if (ERR_W < 9 || TICK_CYCLES < 2) begin : g_param_check
    $error("ERR_W below 9 or TICK_CYCLES below 2");
  end
  localparam int TW = $clog2(TICK_CYCLES);
  function automatic logic [ERR_W-1:0] band_thr(input logic [1:0] code);
    return ERR_W'(`PVLFS_BAND_BASE) << code;
  endfunction

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [6:0]  dither_r, dither_nxt;
  logic [7:0]  sync_r, sync_nxt;
  pvlfs_coef_t norm_r, norm_nxt;
  pvlfs_coef_t fastc_r, fastc_nxt;
  pvlfs_ctl_t  ctl_r, ctl_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic        rvalid_r, rvalid_nxt;
  pvlfs_state_t state_r, state_nxt;

  always_comb begin
    dither_nxt = dither_r;
    sync_nxt   = sync_r;
    norm_nxt   = norm_r;
    fastc_nxt  = fastc_r;
    ctl_nxt    = ctl_r;
    if (reg_wr) begin
      if (reg_addr == `PVLFS_ADDR_DITHER) begin
        dither_nxt = reg_wdata[6:0];
      end else if (reg_addr == `PVLFS_ADDR_SYNC) begin
        sync_nxt = reg_wdata;
      end else if (reg_addr == `PVLFS_ADDR_VGAIN) begin
        norm_nxt.gain = reg_wdata;
      end else if (reg_addr == `PVLFS_ADDR_VZERO) begin
        norm_nxt.zero = reg_wdata;
      end else if (reg_addr == `PVLFS_ADDR_FGAIN) begin
        fastc_nxt.gain = reg_wdata;
      end else if (reg_addr == `PVLFS_ADDR_FZERO) begin
        fastc_nxt.zero = reg_wdata;
      end else if (reg_addr == `PVLFS_ADDR_FCTL) begin
        ctl_nxt = pvlfs_ctl_t'(reg_wdata);
      end
    end
  end

  always_comb begin
    rvalid_nxt = reg_rd;
    rdata_nxt  = rdata_r;
    if (reg_rd) begin
      if (reg_addr == `PVLFS_ADDR_DITHER) begin
        rdata_nxt = {1'b0, dither_r};
      end else if (reg_addr == `PVLFS_ADDR_SYNC) begin
        rdata_nxt = sync_r;
      end else if (reg_addr == `PVLFS_ADDR_VGAIN) begin
        rdata_nxt = norm_r.gain;
      end else if (reg_addr == `PVLFS_ADDR_VZERO) begin
        rdata_nxt = norm_r.zero;
      end else if (reg_addr == `PVLFS_ADDR_FGAIN) begin
        rdata_nxt = fastc_r.gain;
      end else if (reg_addr == `PVLFS_ADDR_FZERO) begin
        rdata_nxt = fastc_r.zero;
      end else if (reg_addr == `PVLFS_ADDR_FCTL) begin
        rdata_nxt = ctl_r;
      end else if (reg_addr == `PVLFS_ADDR_STATUS) begin
        rdata_nxt = {4'h0, state_r, fast_active, 1'b0};
      end else begin
        rdata_nxt = `PVLFS_UNMAPPED_DATA;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dither_r <= `PVLFS_RST_DITHER;
      sync_r   <= `PVLFS_RST_BYTE;
      norm_r   <= {`PVLFS_RST_BYTE, `PVLFS_RST_BYTE};
      fastc_r  <= {`PVLFS_RST_BYTE, `PVLFS_RST_BYTE};
      ctl_r    <= `PVLFS_RST_BYTE;
      rdata_r  <= `PVLFS_RST_BYTE;
      rvalid_r <= 1'b0;
    end else begin
      dither_r <= dither_nxt;
      sync_r   <= sync_nxt;
      norm_r   <= norm_nxt;
      fastc_r  <= fastc_nxt;
      ctl_r    <= ctl_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata  = rdata_r;
  assign reg_rvalid = rvalid_r;

  // ----------------------------------------------------------------
  // Dithering timer and sync divider
  // ----------------------------------------------------------------
  logic [TW-1:0] tick_r, tick_nxt;
  logic [6:0]    per_r, per_nxt;
  logic          dupd_r, dupd_nxt;
  logic [1:0]    scnt_r, scnt_nxt;
  logic          swt_r, swt_nxt;

  always_comb begin
    tick_nxt = tick_r;
    per_nxt  = per_r;
    dupd_nxt = 1'b0;
    scnt_nxt = scnt_r;
    swt_nxt  = 1'b0;
    // dithering update period
    // A period of zero never updates, so dithering is stalled safely.
    if (!dither_en) begin
      tick_nxt = '0;
      per_nxt  = '0;
    end else if (tick_r == TW'(TICK_CYCLES - 1)) begin
      tick_nxt = '0;
      if (dither_r != 7'h00 && per_r + 7'h01 == dither_r) begin
        per_nxt  = '0;
        dupd_nxt = 1'b1;
      end else begin
        per_nxt = per_r + 7'h01;
      end
    end else begin
      tick_nxt = tick_r + TW'(1);
    end
    if (sync_edge) begin
      if (scnt_r >= sync_r[1:0]) begin
        scnt_nxt = '0;
        swt_nxt  = 1'b1;
      end else begin
        scnt_nxt = scnt_r + 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_r <= '0;
      per_r  <= '0;
      dupd_r <= 1'b0;
      scnt_r <= '0;
      swt_r  <= 1'b0;
    end else begin
      tick_r <= tick_nxt;
      per_r  <= per_nxt;
      dupd_r <= dupd_nxt;
      scnt_r <= scnt_nxt;
      swt_r  <= swt_nxt;
    end
  end

  assign dither_update = dupd_r;
  assign sw_tick       = swt_r;

  // ----------------------------------------------------------------
  // Filter selection
  // ----------------------------------------------------------------
  logic [ERR_W-1:0] err_mag;
  logic [ERR_W-1:0] thr;
  logic             out_band;
  logic             overshoot;
  logic             trig;
  logic [2:0]       hcnt_r, hcnt_nxt;
  logic             self_r, self_nxt;
  pvlfs_coef_t      coef_r, coef_nxt;
  assign thr      = band_thr(ctl_r.band);
  assign err_mag  = vout_err[ERR_W-1] ? ERR_W'(-vout_err) : ERR_W'(vout_err);
  assign out_band = err_mag > thr;
  assign overshoot = !vout_err[ERR_W-1] &&
                     (ERR_W'(vout_err) > thr + ERR_W'(`PVLFS_LT_MARGIN));
  assign trig = (ctl_r.lt_en && overshoot) ||
                (ctl_r.ss_en && soft_start) ||
                (ctl_r.dly_en && out_band);

  always_comb begin
    state_nxt = state_r;
    hcnt_nxt  = hcnt_r;
    case (state_r)
      PVLFS_NORMAL: begin
        if (trig) begin
          state_nxt = PVLFS_FAST;
        end
      end
      PVLFS_FAST: begin
        // start return delay once in band
        if (!out_band && !(ctl_r.ss_en && soft_start)) begin
          hcnt_nxt  = '0;
          state_nxt = (ctl_r.delay == 3'h0) ? PVLFS_NORMAL : PVLFS_HOLD;
        end
      end
      PVLFS_HOLD: begin
        if (trig) begin
          state_nxt = PVLFS_FAST;
        end else if (half_cycle) begin
          hcnt_nxt = hcnt_r + 3'h1;
          if (hcnt_r + 3'h1 >= ctl_r.delay) begin
            state_nxt = PVLFS_NORMAL;
          end
        end
      end
      default: begin
        state_nxt = PVLFS_NORMAL;
      end
    endcase
  end

  always_comb begin
    self_nxt = self_r;
    coef_nxt = coef_r;
    if (loop_update) begin
      self_nxt = (state_r != PVLFS_NORMAL);
      coef_nxt = (state_r != PVLFS_NORMAL) ? fastc_r : norm_r;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= PVLFS_NORMAL;
      hcnt_r  <= '0;
      self_r  <= 1'b0;
      coef_r  <= {`PVLFS_RST_BYTE, `PVLFS_RST_BYTE};
    end else begin
      state_r <= state_nxt;
      hcnt_r  <= hcnt_nxt;
      self_r  <= self_nxt;
      coef_r  <= coef_nxt;
    end
  end

  assign coef_out    = coef_r;
  assign fast_active = self_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence seq_last_half;
    state_r == PVLFS_HOLD && !trig && half_cycle &&
      (hcnt_r + 3'h1 >= ctl_r.delay);
  endsequence
  sequence seq_back_normal;
    ##1 state_r == PVLFS_NORMAL;
  endsequence

  a_dither_source: assert property (
    dither_update |-> $past(dither_en) && dither_r != 7'h00)
    else $error("dither update without enable or period");
  a_sync_ratio: assert property (
    sw_tick && sync_r[1:0] == 2'h3 |-> $past(sync_edge) &&
      $past(scnt_r) == 2'h3)
    else $error("sync divide by four broken");
  a_normal_coef: assert property (
    loop_update && state_r == PVLFS_NORMAL |=>
      coef_out == $past(norm_r) && !fast_active)
    else $error("normal coefficients not applied");
  a_fast_coef: assert property (
    loop_update && state_r != PVLFS_NORMAL |=>
      coef_out == $past(fastc_r) && fast_active)
    else $error("fast coefficients not applied");
  a_line_trans: assert property (
    state_r == PVLFS_NORMAL && ctl_r.lt_en && overshoot |=>
      state_r == PVLFS_FAST)
    else $error("line transient did not select fast");
  a_band_edge: assert property (
    ctl_r.band == 2'h2 && err_mag == ERR_W'(65) |-> out_band)
    else $error("band limit decode wrong");
  a_hold_release: assert property (
    seq_last_half |-> seq_back_normal)
    else $error("return delay not honoured");
  a_hold_wait: assert property (
    state_r == PVLFS_HOLD && !trig && !half_cycle |=>
      state_r == PVLFS_HOLD)
    else $error("left hold without half cycle");
  a_soft_start: assert property (
    ctl_r.ss_en && soft_start |=> state_r == PVLFS_FAST)
    else $error("soft start did not hold fast");
  a_delay_trig: assert property (
    ctl_r.dly_en && out_band |=> state_r == PVLFS_FAST)
    else $error("band exit did not select fast");
  a_boundary: assert property (
    !loop_update |=> $stable(fast_active) && $stable(coef_out))
    else $error("coefficient set changed off boundary");
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the voltage loop filter selection block.
// Assumes the map header and package are compiled ahead of this file.
`timescale 1ns/1ps
`default_nettype none
`include "pvlfs_map.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_top;
  import pvlfs_pkg::*;
  localparam int TICK = 3;
  logic               sys_clk = 1'b0;
  logic               reset_n = 1'b0;
  logic [15:0]        reg_addr = 16'h0000;
  logic [7:0]         reg_wdata = 8'h00;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic [7:0]         reg_rdata;
  logic               reg_rvalid;
  logic signed [11:0] vout_err = 12'h000;
  logic               half_cycle = 1'b0;
  logic               soft_start = 1'b0;
  logic               loop_update = 1'b0;
  logic               dither_en = 1'b0;
  logic               sync_edge = 1'b0;
  logic               dither_update;
  logic               sw_tick;
  pvlfs_coef_t        coef_out;
  logic               fast_active;
  int                 failures = 0;
  int                 n_checks = 0;
  int                 n_tick = 0;
  int                 n_dit = 0;
  int                 cnt0 = 0;
  logic [15:0]        adr [7] = '{`PVLFS_ADDR_DITHER, `PVLFS_ADDR_SYNC,
    `PVLFS_ADDR_VGAIN, `PVLFS_ADDR_VZERO, `PVLFS_ADDR_FGAIN,
    `PVLFS_ADDR_FZERO, `PVLFS_ADDR_FCTL};
  int                 dly [2] = '{1, 7};

  always #4 sys_clk = ~sys_clk;

  pvlfs_top #(.ERR_W(12), .TICK_CYCLES(TICK)) DUT (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .vout_err(vout_err),
    .half_cycle(half_cycle), .soft_start(soft_start),
    .loop_update(loop_update), .dither_en(dither_en),
    .sync_edge(sync_edge), .dither_update(dither_update),
    .sw_tick(sw_tick), .coef_out(coef_out), .fast_active(fast_active));

  // Pulses are counted at the edge after they rise, so no race with DUT.
  always @(posedge sys_clk) begin
    if (sw_tick === 1'b1) n_tick <= n_tick + 1;
    if (dither_update === 1'b1) n_dit <= n_dit + 1;
  end

  task automatic tally_and_finish;
    if (failures == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic do_reset;
    reset_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    reset_n = 1'b1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  // Read data is valid for exactly the one cycle after the strobe.
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    `CHK(reg_rvalid, 1'b1)
    `CHK(reg_rdata, e)
    @(negedge sys_clk);
    `CHK(reg_rvalid, 1'b0)
  endtask

  task automatic set_err(input int v);
    @(negedge sys_clk);
    vout_err = v[11:0];
    @(negedge sys_clk);
  endtask

  task automatic pulse_half;
    @(negedge sys_clk);
    half_cycle = 1'b1;
    @(negedge sys_clk);
    half_cycle = 1'b0;
  endtask

  // Outputs only move after a loop update pulse.
  task automatic upd(input logic f);
    @(negedge sys_clk);
    loop_update = 1'b1;
    @(negedge sys_clk);
    loop_update = 1'b0;
    @(negedge sys_clk);
    `CHK(fast_active, f)
    `CHK(coef_out, f ? 16'h3344 : 16'h1122)
  endtask

  initial begin
    repeat (30000) @(posedge sys_clk);
    failures++;
    tally_and_finish();
  end

  initial begin
    do_reset();
    `CHK(fast_active, 1'b0)
    `CHK(coef_out, 16'h0000)
    foreach (adr[i]) rd(adr[i], 8'h00); // zero after reset
    wr(16'hFE1F, 8'h5A);
    rd(16'hFE1F, 8'h00); // unmapped reads zero
    // ------------------------------------------------------------
    // divider ratios
    // ------------------------------------------------------------
    for (int c = 0; c < 4; c++) begin
      do_reset();
      wr(`PVLFS_ADDR_SYNC, 8'hA8 | c[7:0]);
      rd(`PVLFS_ADDR_SYNC, 8'hA8 | c[7:0]); // code readback
      cnt0 = n_tick;
      repeat (12) begin
        @(negedge sys_clk);
        sync_edge = 1'b1;
        @(negedge sys_clk);
        sync_edge = 1'b0;
        @(negedge sys_clk);
      end
      repeat (2) @(negedge sys_clk);
      `CHK(n_tick - cnt0, 12 / (c + 1)) // ticks per edges
    end
    // ------------------------------------------------------------
    // dither period
    // ------------------------------------------------------------
    wr(`PVLFS_ADDR_DITHER, 8'hFF);
    rd(`PVLFS_ADDR_DITHER, 8'h7F); // top bit reserved
    wr(`PVLFS_ADDR_DITHER, 8'h02);
    cnt0 = n_dit;
    dither_en = 1'b1;
    repeat (58) @(negedge sys_clk);
    dither_en = 1'b0;
    `CHK(n_dit - cnt0, 9) // one update per period
    wr(`PVLFS_ADDR_DITHER, 8'h00);
    cnt0 = n_dit;
    dither_en = 1'b1;
    repeat (30) @(negedge sys_clk);
    dither_en = 1'b0;
    `CHK(n_dit - cnt0, 0) // zero period is silent
    // ------------------------------------------------------------
    // Filter selection
    // ------------------------------------------------------------
    wr(`PVLFS_ADDR_VGAIN, 8'h11);
    wr(`PVLFS_ADDR_VZERO, 8'h22);
    wr(`PVLFS_ADDR_FGAIN, 8'h33);
    wr(`PVLFS_ADDR_FZERO, 8'h44);
    for (int i = 2; i < 6; i++) rd(adr[i], 8'h11 * (i - 1)); // sets
    for (int b = 0; b < 4; b++) begin
      wr(`PVLFS_ADDR_FCTL, {1'b0, b[1:0], 3'h0, 1'b0, 1'b1});
      set_err(16 << b);
      upd(1'b0); // edge of band stays normal
      set_err(b[0] ? -(16 << b) - 1 : (16 << b) + 1);
      repeat (3) @(negedge sys_clk);
      `CHK(fast_active, 1'b0) // waits for boundary
      upd(1'b1); // band exit selects fast
      set_err(0);
      upd(1'b0); // zero delay returns
    end
    wr(`PVLFS_ADDR_FCTL, 8'h80);
    set_err(47);
    upd(1'b0); // at margin stays normal
    set_err(-48);
    upd(1'b0); // undershoot ignored
    set_err(48);
    upd(1'b1); // overshoot selects fast
    set_err(0);
    upd(1'b0); // back to normal
    wr(`PVLFS_ADDR_FCTL, 8'h00);
    set_err(100);
    upd(1'b0); // triggers disabled
    set_err(0);
    wr(`PVLFS_ADDR_FCTL, 8'h02);
    soft_start = 1'b1;
    upd(1'b1); // fast during soft start
    soft_start = 1'b0;
    set_err(0);
    upd(1'b0); // normal afterwards
    wr(`PVLFS_ADDR_FCTL, 8'h00);
    soft_start = 1'b1;
    upd(1'b0); // disabled keeps normal
    soft_start = 1'b0;
    foreach (dly[k]) begin
      wr(`PVLFS_ADDR_FCTL, {3'h0, dly[k][2:0], 2'h1});
      set_err(40);
      upd(1'b1); // fast on exit
      set_err(0);
      repeat (dly[k] - 1) pulse_half();
      upd(1'b1); // still holding
      rd(`PVLFS_ADDR_STATUS, 8'h0A); // status shows hold
      pulse_half();
      upd(1'b0); // returns after count
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
